// *** core/rcs_pkg.sv ***
// Shared constants, register map and state types of the reset cause sequencer.
package rcs_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ        = 100;
   localparam int POWERUP_DELAY_TIMER_POR_MS    = 64;
   localparam int POWERUP_DELAY_TIMER_BOR_MS    = 72;
   localparam int BOR_FILT_US    = 100;
   localparam int POWERUP_DELAY_TIMER_POR_CYC   = POWERUP_DELAY_TIMER_POR_MS * 1000 * CLK_MHZ;
   localparam int POWERUP_DELAY_TIMER_BOR_CYC   = POWERUP_DELAY_TIMER_BOR_MS * 1000 * CLK_MHZ;
   localparam int BOR_FILT_CYC   = BOR_FILT_US * CLK_MHZ;
   localparam int OST_CYC        = 1024;
   localparam int PIN_FILT_CYC   = 16;

   // ------------------------------------------------------------------
   // Register map (index; byte address is four times the index)
   // ------------------------------------------------------------------
   localparam int          ADDR_W       = 12;
   localparam logic [9:0]  IDX_STATUS   = 10'h083;
   localparam logic [9:0]  IDX_PWR_CTL  = 10'h08E;
   localparam logic [9:0]  IDX_CONFIG   = 10'h08F;
   localparam logic [9:0]  IDX_STATE    = 10'h090;

   // Status register fields.
   localparam int          ST_WDT_BIT   = 4;
   localparam int          ST_SLP_BIT   = 3;
   localparam logic [2:0]  ST_HI_RST    = 3'h0;
   // Power control fields.
   localparam int          PC_POR_BIT   = 1;
   localparam int          PC_BOR_BIT   = 0;
   localparam logic        PC_BOR_RST   = 1'b1;
   // Configuration fields.
   localparam int          CF_PIN_BIT   = 0;
   localparam int          CF_BOR_BIT   = 1;
   localparam int          CF_POWERUP_DELAY_TIMER_BIT  = 2;
   localparam logic [2:0]  CFG_RST      = 3'h3;

   // Program counter vectors.
   localparam logic [12:0] VEC_RESET    = 13'h0000;
   localparam logic [12:0] VEC_IRQ      = 13'h0004;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_HOLD = 3'h0,
      ST_POWERUP_DELAY_TIMER = 3'h1,
      ST_OST  = 3'h3,
      ST_PIN  = 3'h2,
      ST_RUN  = 3'h6
   } rcs_state_e;

   typedef enum logic [2:0]
   {
      CS_POR     = 3'h0,
      CS_BOR     = 3'h1,
      CS_WDT     = 3'h2,
      CS_PIN_RUN = 3'h3,
      CS_PIN_SLP = 3'h4
   } rcs_cause_e;

endpackage

// *** core/rcs_top.sv ***
// Reset cause sequencer: reset sources, power-up delays, cause flags and APB registers.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module rcs_top
#(
   parameter int POWERUP_DELAY_TIMER_POR_CYCLES = rcs_pkg::POWERUP_DELAY_TIMER_POR_CYC,
   parameter int POWERUP_DELAY_TIMER_BOR_CYCLES = rcs_pkg::POWERUP_DELAY_TIMER_BOR_CYC,
   parameter int BOR_FILT_CYCLES = rcs_pkg::BOR_FILT_CYC,
   parameter int OST_CYCLES      = rcs_pkg::OST_CYC,
   parameter int PIN_FILT_CYCLES = rcs_pkg::PIN_FILT_CYC
)
(
   // Clock and reset
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   // APB slave
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [rcs_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Pins and supply monitors, asynchronous
   input  wire logic                       ext_reset_n,
   input  wire logic                       supply_above_bor,
   input  wire logic                       supply_above_por,
   // Core events, same clock
   input  wire logic                       sleep_mode,
   input  wire logic                       watchdog_timeout,
   input  wire logic                       watchdog_clear_instr,
   input  wire logic                       sleep_enter,
   input  wire logic                       irq_wake,
   input  wire logic                       global_irq_en,
   // Core control
   output logic                            core_reset_n,
   output logic                            ext_reset_pullup_en,
   output logic                            wake_pulse,
   output logic                            vector_pulse,
   output logic      [12:0]                pc_vector
);
   import rcs_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   localparam int NSYNC = 3;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] sync3;
   logic [NSYNC-1:0] stable;

   assign raw_in = {supply_above_por, supply_above_bor, ext_reset_n};

   generate
      for (genvar i = 0; i < NSYNC; i++)
      begin : g_sync
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sync1[i]  <= 1'b1;
               sync2[i]  <= 1'b1;
               sync3[i]  <= 1'b1;
               stable[i] <= 1'b1;
            end
            else
            begin
               sync1[i] <= raw_in[i];
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
               if (sync2[i] == sync3[i])
               begin
                  stable[i] <= sync3[i];
               end
            end
         end
      end
   endgenerate

   logic pin_s;
   logic bor_ok;
   logic por_ok;
   assign pin_s  = stable[0];
   assign bor_ok = stable[1];
   assign por_ok = stable[2];

   // ------------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------------
   rcs_state_e  state;
   rcs_state_e  next_state;
   rcs_cause_e  cause;
   logic [2:0]  cfg;
   logic [7:0]  status;
   logic        pwr_on_flag;
   logic        brownout_flag;
   logic        powerup_delay_timer_long;
   logic        need_timers;
   logic [23:0] cnt;
   logic [13:0] bor_cnt;
   logic [4:0]  pin_cnt;
   logic        pin_low;

   logic ext_reset_pin_en;
   logic brownout_detect_en;
   logic powerup_delay_disable;
   assign ext_reset_pin_en      = cfg[CF_PIN_BIT];
   assign brownout_detect_en    = cfg[CF_BOR_BIT];
   assign powerup_delay_disable = cfg[CF_POWERUP_DELAY_TIMER_BIT];

   // ------------------------------------------------------------------
   // Reset pin glitch filter
   // ------------------------------------------------------------------
   // The pin is only ever sampled; there is no driver on it, so a watchdog
   // reset cannot pull it low.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_cnt <= 5'h00;
         pin_low <= 1'b0;
      end
      else if (pin_s)
      begin
         pin_cnt <= 5'h00;
         pin_low <= 1'b0;
      end
      else if (pin_cnt == 5'(PIN_FILT_CYCLES - 1))
      begin
         pin_low <= 1'b1;
      end
      else
      begin
         pin_cnt <= pin_cnt + 5'h01;
      end
   end

   // ------------------------------------------------------------------
   // Brown-out filter
   // ------------------------------------------------------------------
   // Detection is off in sleep so the power-on detector alone holds reset.
   logic bor_active;
   assign bor_active = brownout_detect_en && !sleep_mode;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bor_cnt <= 14'h0000;
      end
      else if (!bor_active || bor_ok)
      begin
         bor_cnt <= 14'h0000;
      end
      else if (bor_cnt != 14'(BOR_FILT_CYCLES))
      begin
         bor_cnt <= bor_cnt + 14'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Reset and wake events
   // ------------------------------------------------------------------
   logic ev_por;
   logic ev_bor;
   logic ev_pin;
   logic ev_wdt_rst;
   logic ev_wdt_wake;
   logic ev_irq_wake;
   logic any_rst;
   logic running;
   logic supply_ok;

   assign running     = (state == ST_RUN);
   assign ev_por      = !por_ok;
   assign ev_bor      = bor_active && !bor_ok
                        && (bor_cnt == 14'(BOR_FILT_CYCLES) || state == ST_POWERUP_DELAY_TIMER);
   assign ev_pin      = ext_reset_pin_en && pin_low && running;
   assign ev_wdt_rst  = watchdog_timeout && !sleep_mode && running;
   assign ev_wdt_wake = watchdog_timeout && sleep_mode && running;
   assign ev_irq_wake = irq_wake && sleep_mode && running;
   assign any_rst     = ev_por || ev_bor || ev_pin || ev_wdt_rst;
   assign supply_ok   = por_ok && (!bor_active || bor_ok);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   logic [23:0] powerup_delay_timer_target;
   assign powerup_delay_timer_target = powerup_delay_timer_long ? 24'(POWERUP_DELAY_TIMER_BOR_CYCLES - 1)
                                  : 24'(POWERUP_DELAY_TIMER_POR_CYCLES - 1);

   always_comb
   begin
      next_state = state;
      if (any_rst)
      begin
         next_state = ST_HOLD;
      end
      else
      begin
         unique case (state)
            ST_HOLD:
            begin
               if (supply_ok && need_timers && !powerup_delay_disable)
                  next_state = ST_POWERUP_DELAY_TIMER;
               else if (supply_ok && need_timers)
                  next_state = ST_OST;
               else if (supply_ok)
                  next_state = ST_PIN;
            end
            ST_POWERUP_DELAY_TIMER:
            begin
               if (cnt == powerup_delay_timer_target)
                  next_state = ST_OST;
            end
            ST_OST:
            begin
               if (cnt == 24'(OST_CYCLES - 1))
                  next_state = ST_PIN;
            end
            ST_PIN:
            begin
               if (!(ext_reset_pin_en && pin_low))
                  next_state = ST_RUN;
            end
            ST_RUN:
            begin
               next_state = ST_RUN;
            end
            default:
            begin
               next_state = ST_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state        <= ST_HOLD;
         core_reset_n <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         core_reset_n <= (next_state == ST_RUN);
      end
   end

   // One shared counter serves both timers; it restarts on every state change.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 24'h000000;
      end
      else if (next_state != state || any_rst)
      begin
         cnt <= 24'h000000;
      end
      else if (state == ST_POWERUP_DELAY_TIMER || state == ST_OST)
      begin
         cnt <= cnt + 24'h000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cause       <= CS_POR;
         need_timers <= 1'b1;
         powerup_delay_timer_long   <= 1'b0;
      end
      else if (ev_por)
      begin
         cause       <= CS_POR;
         need_timers <= 1'b1;
         powerup_delay_timer_long   <= 1'b0;
      end
      else if (ev_bor)
      begin
         cause       <= CS_BOR;
         need_timers <= 1'b1;
         powerup_delay_timer_long   <= 1'b1;
      end
      else if (ev_pin)
      begin
         cause       <= sleep_mode ? CS_PIN_SLP : CS_PIN_RUN;
         need_timers <= 1'b0;
      end
      else if (ev_wdt_rst)
      begin
         cause       <= CS_WDT;
         need_timers <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Cause flags
   // ------------------------------------------------------------------
   logic wr_en;
   logic [9:0] idx;
   assign idx   = paddr[ADDR_W-1:2];
   assign wr_en = psel && penable && pready && pwrite;

   // Hardware events win over a software write in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_on_flag   <= 1'b0;
         brownout_flag <= PC_BOR_RST;
      end
      else if (ev_por)
      begin
         pwr_on_flag   <= 1'b0;
      end
      else if (ev_bor)
      begin
         brownout_flag <= 1'b0;
      end
      else if (wr_en && idx == IDX_PWR_CTL)
      begin
         pwr_on_flag   <= pwdata[PC_POR_BIT];
         brownout_flag <= pwdata[PC_BOR_BIT];
      end
   end

   // Low status bits are unaffected by every reset but the bus reset; upper bits clear on resets
   // but not on wake-ups, which resume normal execution.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status <= {ST_HI_RST, 1'b1, 1'b1, 3'h0};
      end
      else if (ev_por || ev_bor)
      begin
         status[7:5]        <= ST_HI_RST;
         status[ST_WDT_BIT] <= 1'b1;
         status[ST_SLP_BIT] <= 1'b1;
      end
      else if (ev_pin)
      begin
         status[7:5] <= ST_HI_RST;
         if (sleep_mode)
            status[ST_SLP_BIT] <= 1'b0;
      end
      else if (ev_wdt_rst)
      begin
         status[7:5]        <= ST_HI_RST;
         status[ST_WDT_BIT] <= 1'b0;
      end
      else if (ev_wdt_wake)
      begin
         status[ST_WDT_BIT] <= 1'b0;
         status[ST_SLP_BIT] <= 1'b0;
      end
      else if (ev_irq_wake)
      begin
         status[ST_SLP_BIT] <= 1'b0;
      end
      else if (watchdog_clear_instr)
      begin
         status[ST_WDT_BIT] <= 1'b1;
         status[ST_SLP_BIT] <= 1'b1;
      end
      else if (sleep_enter)
      begin
         status[ST_WDT_BIT] <= 1'b1;
         status[ST_SLP_BIT] <= 1'b0;
      end
      else if (wr_en && idx == IDX_STATUS)
      begin
         status[7:5] <= pwdata[7:5];
         status[2:0] <= pwdata[2:0];
      end
   end

   // ------------------------------------------------------------------
   // Program counter steering
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_pulse   <= 1'b0;
         vector_pulse <= 1'b0;
         pc_vector    <= VEC_RESET;
      end
      else
      begin
         wake_pulse   <= (ev_wdt_wake || ev_irq_wake) && !any_rst;
         vector_pulse <= ev_irq_wake && global_irq_en && !any_rst;
         if (any_rst)
            pc_vector <= VEC_RESET;
         else if (ev_irq_wake && global_irq_en)
            pc_vector <= VEC_IRQ;
      end
   end

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   // Configuration survives every reset except the bus reset, like a fuse word.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg                 <= CFG_RST;
         ext_reset_pullup_en <= 1'b0;
      end
      else
      begin
         if (wr_en && idx == IDX_CONFIG)
            cfg <= pwdata[2:0];
         ext_reset_pullup_en <= ext_reset_pin_en;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata <= 32'h00000000;
            unique case (idx)
               IDX_STATUS:  prdata[7:0] <= status;
               IDX_PWR_CTL:
               begin
                  prdata[PC_POR_BIT] <= pwr_on_flag;
                  prdata[PC_BOR_BIT] <= brownout_flag;
               end
               IDX_CONFIG:  prdata[2:0] <= cfg;
               IDX_STATE:   prdata[6:0] <= {core_reset_n, cause, state};
               default:     pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // The core may only leave reset from the pin wait, never by skipping that stage.
   chk_core_released: assert property ($rose(core_reset_n) |-> $past(state) == ST_PIN)
      else $error("core released without passing the pin wait");
   chk_por_flag_clr: assert property (ev_por |=> !pwr_on_flag && !core_reset_n)
      else $error("power-on did not clear flag and hold reset");
   chk_bor_flags: assert property (ev_bor && !ev_por
      |=> !brownout_flag && status[ST_WDT_BIT] && status[ST_SLP_BIT])
      else $error("brown-out flags wrong");
   chk_wdt_reset: assert property (ev_wdt_rst && !ev_por && !ev_bor && !ev_pin
      |=> !status[ST_WDT_BIT] && !core_reset_n && status[7:5] == ST_HI_RST)
      else $error("watchdog reset not recorded");
   chk_wdt_wake: assert property (ev_wdt_wake && !any_rst
      |=> core_reset_n && wake_pulse && !status[ST_WDT_BIT] && !status[ST_SLP_BIT])
      else $error("watchdog wake handled wrongly");
   chk_powerup_delay_timer_length: assert property (state == ST_OST && $past(state) == ST_POWERUP_DELAY_TIMER
      |-> $past(cnt) == $past(powerup_delay_timer_target))
      else $error("power-up delay left early");
   chk_hold_supply: assert property (state == ST_HOLD && !supply_ok |=> state == ST_HOLD)
      else $error("left hold with supply low");
   chk_powerup_delay_timer_drop: assert property (state == ST_POWERUP_DELAY_TIMER && bor_active && !bor_ok
      |=> state == ST_HOLD && cnt == 24'h000000 ##1 powerup_delay_timer_long)
      else $error("supply drop did not restart delay");
   chk_pin_hold: assert property (state == ST_PIN && ext_reset_pin_en && pin_low
      && !any_rst |=> state == ST_PIN)
      else $error("left pin wait while pin held");
   chk_irq_vector: assert property (ev_irq_wake && global_irq_en && !any_rst
      |=> vector_pulse && pc_vector == VEC_IRQ ##1 !vector_pulse)
      else $error("interrupt vector not loaded");
   chk_pin_filter: assert property (!pin_s |-> !pin_low || $past(!pin_s, 2))
      else $error("reset pin glitch passed filter");

   cov_power_up: cover property (state == ST_POWERUP_DELAY_TIMER ##[1:200] state == ST_RUN);
   cov_bor_restart: cover property (state == ST_POWERUP_DELAY_TIMER ##1 state == ST_HOLD);
   cov_wdt_wake: cover property (ev_wdt_wake);
   cov_pin_reset: cover property (ev_pin ##[1:50] core_reset_n);

endmodule

`default_nettype wire

// *** bench/rcs_partner.sv ***
// Model of the supply monitors and the pulled-up reset pin beside the sequencer.
`timescale 1ns/1ns
`default_nettype none
module rcs_partner
(
   // Commands from the bench
   input  wire logic por_ok,
   input  wire logic bor_ok,
   input  wire logic pin_low,
   // Lines seen by the sequencer
   output logic      supply_above_por,
   output logic      supply_above_bor,
   output logic      ext_reset_n
);
   // A supply under the power-on level is also under the brown-out level.
   assign supply_above_por = por_ok;
   assign supply_above_bor = bor_ok & por_ok;
   // A released pin floats high through its weak pull-up, never to its last value.
   assign ext_reset_n = ~pin_low;
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the reset cause sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb;
   import rcs_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sleep_mode, watchdog_timeout, watchdog_clear_instr, sleep_enter;
   logic        irq_wake, global_irq_en, core_reset_n, ext_reset_pullup_en;
   logic        wake_pulse, vector_pulse, por_ok, bor_ok, pin_low;
   logic        supply_above_por, supply_above_bor, ext_reset_n;
   logic [12:0] pc_vector;
   int          fails = 0, n_tests = 0, cyc = 0, n;
   localparam logic [11:0] A_ST = {IDX_STATUS, 2'b00};
   localparam logic [11:0] A_PC = {IDX_PWR_CTL, 2'b00};
   localparam logic [11:0] A_CF = {IDX_CONFIG, 2'b00};

   rcs_top #(.POWERUP_DELAY_TIMER_POR_CYCLES(64), .POWERUP_DELAY_TIMER_BOR_CYCLES(72), .BOR_FILT_CYCLES(10),
      .OST_CYCLES(8), .PIN_FILT_CYCLES(4)) i_rcs_top (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_reset_n,
      .supply_above_bor, .supply_above_por, .sleep_mode, .watchdog_timeout,
      .watchdog_clear_instr, .sleep_enter, .irq_wake, .global_irq_en, .core_reset_n,
      .ext_reset_pullup_en, .wake_pulse, .vector_pulse, .pc_vector);
   rcs_partner i_rcs_partner (.por_ok, .bor_ok, .pin_low, .supply_above_por,
      .supply_above_bor, .ext_reset_n);

   initial
   begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   // The whole run needs about five hundred cycles.
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         fails++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task wait_core();
      n = 0;
      while (core_reset_n !== 1'b1)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, presetn, pin_low} = '0;
      {sleep_mode, watchdog_timeout, watchdog_clear_instr, sleep_enter} = '0;
      {irq_wake, global_irq_en, por_ok, bor_ok} = 4'b0011;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wait_core();
      `CHK("por_delay", 1'b1, n >= 72 && n <= 90)
      apb(0, A_PC, 0);
      `CHK("pwr_ctl_por", 32'h1, rd)
      apb(0, A_ST, 0);
      `CHK("status_por", 8'h18, rd[7:0])
      `CHK("pc_reset", VEC_RESET, pc_vector)
      apb(1, A_PC, 32'h3);
      pin_low <= 1'b1;
      repeat (2) @(posedge pclk);
      pin_low <= 1'b0;
      repeat (10) @(posedge pclk);
      `CHK("glitch", 1'b1, core_reset_n)
      pin_low <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK("pin_rst", 1'b0, core_reset_n)
      pin_low <= 1'b0;
      wait_core();
      apb(0, A_PC, 0);
      `CHK("pwr_ctl_pin", 32'h3, rd)
      apb(1, A_ST, 32'hE7);
      watchdog_timeout <= 1'b1;
      @(posedge pclk);
      watchdog_timeout <= 1'b0;
      #1 `CHK("wdt_rst", 1'b0, core_reset_n)
      wait_core();
      apb(0, A_ST, 0);
      `CHK("status_wdt", 8'h0F, rd[7:0])
      sleep_enter <= 1'b1;
      @(posedge pclk);
      {sleep_enter, sleep_mode, watchdog_timeout} <= 3'b011;
      @(posedge pclk);
      watchdog_timeout <= 1'b0;
      #1 `CHK("wdt_wake", 2'b11, {wake_pulse, core_reset_n})
      // The core goes back to sleep before the interrupt wakes it again.
      @(posedge pclk);
      sleep_enter <= 1'b1;
      @(posedge pclk);
      {sleep_enter, irq_wake, global_irq_en} <= 3'b011;
      @(posedge pclk);
      irq_wake <= 1'b0;
      #1 `CHK("irq_vec", 1'b1, vector_pulse)
      @(posedge pclk);
      sleep_mode <= 1'b0;
      #1 `CHK("pc_irq", VEC_IRQ, pc_vector)
      apb(0, A_ST, 0);
      `CHK("status_wake", 2'b10, rd[4:3])
      watchdog_clear_instr <= 1'b1;
      @(posedge pclk);
      watchdog_clear_instr <= 1'b0;
      apb(0, A_ST, 0);
      `CHK("status_clr", 2'b11, rd[4:3])
      bor_ok <= 1'b0;
      repeat (25) @(posedge pclk);
      `CHK("bor_rst", 1'b0, core_reset_n)
      bor_ok <= 1'b1;
      repeat (30) @(posedge pclk);
      bor_ok <= 1'b0;
      repeat (3) @(posedge pclk);
      bor_ok <= 1'b1;
      wait_core();
      `CHK("bor_delay", 1'b1, n >= 80)
      apb(0, A_PC, 0);
      `CHK("pwr_ctl_bor", 32'h2, rd)
      apb(1, A_CF, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("pullup_off", 1'b0, ext_reset_pullup_en)
      pin_low <= 1'b1;
      repeat (20) @(posedge pclk);
      `CHK("pin_off", 1'b1, core_reset_n)
      pin_low <= 1'b0;
      apb(0, 12'hFFC, 32'h0);
      `CHK("unmapped", 1'b1, err)
      // Supply dip below the power-on level with the power-up delay disabled.
      apb(1, A_CF, 32'h7);
      por_ok <= 1'b0;
      repeat (10) @(posedge pclk);
      `CHK("por_rst", 1'b0, core_reset_n)
      por_ok <= 1'b1;
      wait_core();
      `CHK("powerup_delay_timer_off", 1'b1, n >= 8 && n <= 30)
      apb(0, A_PC, 0);
      `CHK("pwr_ctl_por2", 32'h0, rd)
      apb(0, A_ST, 0);
      `CHK("status_por2", 5'h03, rd[7:3])
      {pin_low, presetn} <= 2'b10;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (120) @(posedge pclk);
      `CHK("pin_hold", 1'b0, core_reset_n)
      pin_low <= 1'b0;
      wait_core();
      `CHK("pin_release", 1'b1, n <= 12)
      give_verdict();
   end
endmodule
`default_nettype wire
